/* File: shared/fcs_consts.vh */
/*
 * constants for the flash command/status controller: register map,
 * controller command codes, flash command words and bus timing.
 * assumes a 100 MHz pclk and a word-wide (x16) parallel flash.
 */
`ifndef FCS_CONSTS_VH
`define FCS_CONSTS_VH

// ****************************************
// apb register map (byte offsets)
// ****************************************
`define FCS_REG_CTRL    8'h00
`define FCS_REG_ADDR    8'h04
`define FCS_REG_WDATA   8'h08
`define FCS_REG_STATUS  8'h0c
`define FCS_REG_RDATA   8'h10

// ****************************************
// controller commands (ctrl[3:0])
// ****************************************
`define FCS_OP_READ      4'h0
`define FCS_OP_RESET     4'h1
`define FCS_OP_PROG      4'h2
`define FCS_OP_BYP_ENTER 4'h3
`define FCS_OP_BYP_PROG  4'h4
`define FCS_OP_BYP_RESET 4'h5
`define FCS_OP_CHIP_ER   4'h6
`define FCS_OP_SECT_ER   4'h7
`define FCS_OP_SUSPEND   4'h8
`define FCS_OP_RESUME    4'h9
`define FCS_OP_AUTOSEL   4'ha
`define FCS_OP_POLL      4'hb
`define FCS_OP_LAST      4'hb

// ****************************************
// status register fields
// ****************************************
`define FCS_ST_BUSY      0
`define FCS_ST_DONE      1
`define FCS_ST_ERR       2
`define FCS_ST_TIMEOUT   3
`define FCS_ST_BYPASS    4
`define FCS_ST_ERASING   5
`define FCS_ST_SUSP      6
`define FCS_ST_RDY_PIN   7

// ****************************************
// flash command words (word mode)
// ****************************************
`define FCS_UNLOCK_A1    16'h0555
`define FCS_UNLOCK_A2    16'h02aa
`define FCS_D_UNLOCK1    8'haa
`define FCS_D_UNLOCK2    8'h55
`define FCS_D_RESET      8'hf0
`define FCS_D_PROGRAM    8'ha0
`define FCS_D_BYPASS     8'h20
`define FCS_D_AUTOSEL    8'h90
`define FCS_D_BYP_EXIT   8'h00
`define FCS_D_ERASE      8'h80
`define FCS_D_CHIP       8'h10
`define FCS_D_SECTOR     8'h30
`define FCS_D_SUSPEND    8'hb0
`define FCS_D_RESUME     8'h30

// ****************************************
// data bit positions of the status word
// ****************************************
`define FCS_DQ_POLLING   7
`define FCS_DQ_TOGGLE1   6
`define FCS_DQ_TIMEOUT   5

// ****************************************
// bus timing
// ****************************************
`define FCS_CLK_NS       10
`define FCS_T_SETUP_NS   10
`define FCS_T_WP_NS      35
`define FCS_T_ACC_NS     70
`define FCS_CYC(ns)      (((ns) + `FCS_CLK_NS - 1) / `FCS_CLK_NS)

`endif

/* File: rtl/fcs_bus_cycle.v */
/*
 * one asynchronous flash bus cycle, write or read, paced by pclk.
 * assumes start is only raised while the engine is idle; write, addr
 * and wdata are registered on the clock edge that takes start.
 */
`include "fcs_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module fcs_bus_cycle
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        start,
  input  wire        write,
  input  wire [18:0] addr,
  input  wire [15:0] wdata,
  output reg         done,
  output reg  [15:0] rdata,
  output reg  [18:0] flash_addr,
  output reg  [15:0] flash_dq_out,
  output reg         flash_dq_oe,
  input  wire [15:0] flash_dq_in,
  output reg         flash_ce_n,
  output reg         flash_we_n,
  output reg         flash_oe_n
);

  localparam [1:0] S_IDLE   = 2'd0;
  localparam [1:0] S_SETUP  = 2'd1;
  localparam [1:0] S_STROBE = 2'd2;
  localparam [1:0] S_RECOV  = 2'd3;

  localparam integer SETUP_I = `FCS_CYC(`FCS_T_SETUP_NS);
  localparam integer WP_I    = `FCS_CYC(`FCS_T_WP_NS);
  localparam integer ACC_I   = `FCS_CYC(`FCS_T_ACC_NS);
  localparam [3:0] CYC_SETUP = SETUP_I[3:0];
  localparam [3:0] CYC_WP    = WP_I[3:0];
  localparam [3:0] CYC_ACC   = ACC_I[3:0];

  reg [1:0] state;
  reg [3:0] cnt;
  reg       is_write;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= S_IDLE;
      cnt          <= 4'h0;
      is_write     <= 1'b0;
      done         <= 1'b0;
      rdata        <= 16'h0000;
      flash_addr   <= 19'h00000;
      flash_dq_out <= 16'h0000;
      flash_dq_oe  <= 1'b0;
      flash_ce_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (start)
          begin
            // chip select falls first, so the strobe fall is the later edge
            flash_addr   <= addr;
            flash_dq_out <= wdata;
            flash_dq_oe  <= write;
            is_write     <= write;
            flash_ce_n   <= 1'b0;
            cnt          <= CYC_SETUP - 4'h1;
            state        <= S_SETUP;
          end
        end
        S_SETUP:
        begin
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
          begin
            flash_we_n <= ~is_write;
            flash_oe_n <= is_write;
            cnt        <= (is_write ? CYC_WP : CYC_ACC) - 4'h1;
            state      <= S_STROBE;
          end
        end
        S_STROBE:
        begin
          if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
          else
          begin
            // write strobe rises while select is still low: earlier rising edge
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            if (!is_write)
              rdata <= flash_dq_in;
            state <= S_RECOV;
          end
        end
        S_RECOV:
        begin
          // data stays driven one cycle past the strobe for hold time
          flash_ce_n  <= 1'b1;
          flash_dq_oe <= 1'b0;
          done        <= 1'b1;
          state       <= S_IDLE;
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

endmodule // fcs_bus_cycle

`default_nettype wire

/* File: rtl/fcs_host.v */
/*
 * host-side controller for an eight-bank parallel flash: software orders
 * command sequences and status polls over apb; results show in status
 * and read-data registers. assumes a x16 flash with word addressing and
 * an external pull-up on the open-drain ready/busy line.
 */
// The APB register port and the register offsets are this design's own decisions.
`include "fcs_consts.vh"
`timescale 1ns/100ps
`default_nettype none

module fcs_host
(
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [18:0] flash_addr,
  output wire [15:0] flash_dq_out,
  output wire        flash_dq_oe,
  input  wire [15:0] flash_dq_in,
  output wire        flash_ce_n,
  output wire        flash_we_n,
  output wire        flash_oe_n,
  input  wire        ready_busy_n
);

  // ****************************************
  // sequence tables
  // ****************************************
  function [2:0] seq_len;
    input [3:0] op;
    begin
      case (op)
        `FCS_OP_PROG, `FCS_OP_AUTOSEL:  seq_len = 3'd4;
        `FCS_OP_BYP_ENTER:              seq_len = 3'd3;
        `FCS_OP_BYP_PROG, `FCS_OP_BYP_RESET: seq_len = 3'd2;
        `FCS_OP_CHIP_ER, `FCS_OP_SECT_ER:    seq_len = 3'd6;
        default:                        seq_len = 3'd1;
      endcase
    end
  endfunction

  // returns {is_read, address, data} for one cycle of a sequence
  function [35:0] seq_cycle;
    input [3:0]  op;
    input [2:0]  step;
    input [18:0] a;
    input [15:0] d;
    reg   [18:0] bank;
    reg   [18:0] sector;
    reg   [18:0] u1;
    reg   [18:0] u2;
    begin
      bank   = {a[18:16], 16'h0000};
      sector = {a[18:12], 12'h000};
      u1     = {3'b000, `FCS_UNLOCK_A1};
      u2     = {3'b000, `FCS_UNLOCK_A2};
      seq_cycle = {1'b0, u1, 8'h00, `FCS_D_UNLOCK1};
      case (op)
        `FCS_OP_READ, `FCS_OP_POLL:
          seq_cycle = {1'b1, a, 16'h0000};
        `FCS_OP_RESET:
          seq_cycle = {1'b0, bank, 8'h00, `FCS_D_RESET};
        `FCS_OP_SUSPEND:
          seq_cycle = {1'b0, bank, 8'h00, `FCS_D_SUSPEND};
        `FCS_OP_RESUME:
          seq_cycle = {1'b0, bank, 8'h00, `FCS_D_RESUME};
        `FCS_OP_BYP_PROG:
          if (step == 3'd0)
            seq_cycle = {1'b0, 19'h00000, 8'h00, `FCS_D_PROGRAM};
          else
            seq_cycle = {1'b0, a, d};
        `FCS_OP_BYP_RESET:
          if (step == 3'd0)
            seq_cycle = {1'b0, bank, 8'h00, `FCS_D_AUTOSEL};
          else
            seq_cycle = {1'b0, 19'h00000, 8'h00, `FCS_D_BYP_EXIT};
        default:
        begin
          case (step)
            3'd0: seq_cycle = {1'b0, u1, 8'h00, `FCS_D_UNLOCK1};
            3'd1: seq_cycle = {1'b0, u2, 8'h00, `FCS_D_UNLOCK2};
            3'd2:
              case (op)
                `FCS_OP_PROG:      seq_cycle = {1'b0, u1, 8'h00, `FCS_D_PROGRAM};
                `FCS_OP_BYP_ENTER: seq_cycle = {1'b0, u1, 8'h00, `FCS_D_BYPASS};
                `FCS_OP_AUTOSEL:   seq_cycle = {1'b0, bank | u1, 8'h00, `FCS_D_AUTOSEL};
                default:           seq_cycle = {1'b0, u1, 8'h00, `FCS_D_ERASE};
              endcase
            3'd3:
              if (op == `FCS_OP_PROG)
                seq_cycle = {1'b0, a, d};
              else if (op == `FCS_OP_AUTOSEL)
                seq_cycle = {1'b1, a, 16'h0000};
              else
                seq_cycle = {1'b0, u1, 8'h00, `FCS_D_UNLOCK1};
            3'd4: seq_cycle = {1'b0, u2, 8'h00, `FCS_D_UNLOCK2};
            default:
              if (op == `FCS_OP_SECT_ER)
                seq_cycle = {1'b0, sector, 8'h00, `FCS_D_SECTOR};
              else
                seq_cycle = {1'b0, u1, 8'h00, `FCS_D_CHIP};
          endcase
        end
      endcase
    end
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_SEQ  = 2'd1;
  localparam [1:0] S_POLL = 2'd2;
  localparam [1:0] S_LAST = 2'd3;

  reg  [1:0]  state;
  reg  [3:0]  op;
  reg  [2:0]  step;
  reg  [18:0] addr_reg;
  reg  [15:0] wdata_reg;
  reg  [15:0] rdata_reg;
  reg         done_flag;
  reg         err_flag;
  reg         timeout_seen;
  reg         timeout_hit;
  reg         bypass;
  reg         erasing;
  reg         suspended;
  reg         first_read;
  reg         prev_toggle;
  reg         eng_start;
  reg         eng_write;
  reg  [18:0] eng_addr;
  reg  [15:0] eng_wdata;
  wire        eng_done;
  wire [15:0] eng_rdata;
  wire [35:0] cyc_now;
  wire [35:0] cyc_next;
  wire [2:0]  op_len;
  wire        setup_ph;
  wire        wr_ctrl;
  wire        legal;
  wire        mapped;
  wire        new_toggle;

  assign pready   = 1'b1;
  assign setup_ph = psel & ~penable;
  assign mapped   = (paddr == `FCS_REG_CTRL) | (paddr == `FCS_REG_ADDR) | (paddr == `FCS_REG_WDATA) |
                    (paddr == `FCS_REG_STATUS) | (paddr == `FCS_REG_RDATA);
  assign pslverr  = psel & penable & ~mapped;
  assign wr_ctrl  = psel & penable & pwrite & (paddr == `FCS_REG_CTRL) & (state == S_IDLE);
  assign op_len   = seq_len(op);
  assign cyc_now  = seq_cycle(pwdata[3:0], 3'd0, addr_reg, wdata_reg);
  assign cyc_next = seq_cycle(op, step + 3'd1, addr_reg, wdata_reg);
  assign new_toggle = eng_rdata[`FCS_DQ_TOGGLE1];

  // bypass mode accepts only its own program, exit, reads and polls
  assign legal = (pwdata[3:0] <= `FCS_OP_LAST) &&
                 (pwdata[3:0] != `FCS_OP_BYP_PROG || bypass) &&
                 (!bypass || pwdata[3:0] == `FCS_OP_BYP_PROG || pwdata[3:0] == `FCS_OP_BYP_RESET ||
                  pwdata[3:0] == `FCS_OP_READ || pwdata[3:0] == `FCS_OP_POLL) &&
                 (pwdata[3:0] != `FCS_OP_SUSPEND || (erasing && !suspended)) &&
                 (pwdata[3:0] != `FCS_OP_RESUME || suspended);

  // ****************************************
  // apb register file
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata    <= 32'h00000000;
      addr_reg  <= 19'h00000;
      wdata_reg <= 16'h0000;
    end
    else
    begin
      if (psel & penable & pwrite & (paddr == `FCS_REG_ADDR))
        addr_reg <= pwdata[18:0];
      if (psel & penable & pwrite & (paddr == `FCS_REG_WDATA))
        wdata_reg <= pwdata[15:0];
      if (setup_ph & ~pwrite)
      begin
        case (paddr)
          `FCS_REG_CTRL:   prdata <= {28'h0000000, op};
          `FCS_REG_ADDR:   prdata <= {13'h0000, addr_reg};
          `FCS_REG_WDATA:  prdata <= {16'h0000, wdata_reg};
          `FCS_REG_STATUS: prdata <= {24'h000000, ready_busy_n, suspended, erasing, bypass,
                                      timeout_hit, err_flag, done_flag, state != S_IDLE};
          `FCS_REG_RDATA:  prdata <= {16'h0000, rdata_reg};
          default:         prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************
  // command sequencer and status poll
  // ****************************************
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= S_IDLE;
      op           <= `FCS_OP_READ;
      step         <= 3'd0;
      rdata_reg    <= 16'h0000;
      done_flag    <= 1'b0;
      err_flag     <= 1'b0;
      timeout_seen <= 1'b0;
      timeout_hit  <= 1'b0;
      bypass       <= 1'b0;
      erasing      <= 1'b0;
      suspended    <= 1'b0;
      first_read   <= 1'b0;
      prev_toggle  <= 1'b0;
      eng_start    <= 1'b0;
      eng_write    <= 1'b0;
      eng_addr     <= 19'h00000;
      eng_wdata    <= 16'h0000;
    end
    else
    begin
      eng_start <= 1'b0;
      case (state)
        S_IDLE:
        begin
          if (wr_ctrl)
          begin
            op        <= pwdata[3:0];
            step      <= 3'd0;
            done_flag <= ~legal;
            err_flag  <= ~legal;
            if (legal)
            begin
              eng_start <= 1'b1;
              eng_write <= ~cyc_now[35];
              eng_addr  <= cyc_now[34:16];
              eng_wdata <= cyc_now[15:0];
              state     <= S_SEQ;
            end
          end
        end
        S_SEQ:
        begin
          if (eng_done)
          begin
            if (!eng_write)
              rdata_reg <= eng_rdata;
            if (step == op_len - 3'd1)
            begin
              // state of the flash as this controller tracks it
              case (op)
                `FCS_OP_BYP_ENTER: bypass <= 1'b1;
                `FCS_OP_BYP_RESET: bypass <= 1'b0;
                `FCS_OP_CHIP_ER, `FCS_OP_SECT_ER: erasing <= 1'b1;
                `FCS_OP_SUSPEND:   suspended <= 1'b1;
                `FCS_OP_RESUME:    suspended <= 1'b0;
                `FCS_OP_RESET:     timeout_hit <= 1'b0;
                default:           erasing <= erasing;
              endcase
              if (op == `FCS_OP_PROG || op == `FCS_OP_BYP_PROG || op == `FCS_OP_POLL)
              begin
                // first poll read follows the final write strobe rise, or the single sequence read of a poll
                first_read   <= 1'b1;
                timeout_seen <= 1'b0;
                eng_start    <= 1'b1;
                eng_write    <= 1'b0;
                eng_wdata    <= 16'h0000;
                eng_addr     <= addr_reg;
                state        <= S_POLL;
              end
              else
              begin
                done_flag <= 1'b1;
                state     <= S_IDLE;
              end
            end
            else
            begin
              step      <= step + 3'd1;
              eng_start <= 1'b1;
              eng_write <= ~cyc_next[35];
              eng_addr  <= cyc_next[34:16];
              eng_wdata <= cyc_next[15:0];
            end
          end
        end
        S_POLL:
        begin
          // busy-bank reads flip toggle bit one; it stops on completion, on
          // suspend, and after the short busy of protected targets
          if (eng_done)
          begin
            prev_toggle <= new_toggle;
            first_read  <= 1'b0;
            eng_start   <= 1'b1;
            if (!first_read && new_toggle == prev_toggle)
              state <= S_LAST;
            else if (!first_read && eng_rdata[`FCS_DQ_TIMEOUT])
            begin
              // toggle rechecked once after the flag rose, then failure
              if (timeout_seen)
              begin
                eng_start   <= 1'b0;
                timeout_hit <= 1'b1;
                err_flag    <= 1'b1;
                done_flag   <= 1'b1;
                rdata_reg   <= eng_rdata;
                state       <= S_IDLE;
              end
              timeout_seen <= 1'b1;
            end
          end
        end
        S_LAST:
        begin
          // near completion bits 6..0 may lag, so one more read is kept
          if (eng_done)
          begin
            rdata_reg <= eng_rdata;
            done_flag <= 1'b1;
            if (!suspended)
              erasing <= 1'b0;
            state <= S_IDLE;
          end
        end
        default:
          state <= S_IDLE;
      endcase
    end
  end

  fcs_bus_cycle u_cycle
  (
    .pclk         (pclk),
    .presetn      (presetn),
    .start        (eng_start),
    .write        (eng_write),
    .addr         (eng_addr),
    .wdata        (eng_wdata),
    .done         (eng_done),
    .rdata        (eng_rdata),
    .flash_addr   (flash_addr),
    .flash_dq_out (flash_dq_out),
    .flash_dq_oe  (flash_dq_oe),
    .flash_dq_in  (flash_dq_in),
    .flash_ce_n   (flash_ce_n),
    .flash_we_n   (flash_we_n),
    .flash_oe_n   (flash_oe_n)
  );

endmodule // fcs_host

`default_nettype wire

/* File: tb/fcs_host_props.sv */
/* strobe timing and apb answer checks for fcs_host.
   assumes binding to fcs_host: one clock, async active-low reset. */
`timescale 1ns/100ps
`default_nettype none
module fcs_props
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pslverr,
  input wire logic [18:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic        flash_dq_oe,
  input wire logic        flash_ce_n,
  input wire logic        flash_we_n,
  input wire logic        flash_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence we_low4; (!flash_we_n)[*4] ##1 flash_we_n; endsequence
  sequence oe_low7; (!flash_oe_n)[*7] ##1 flash_oe_n; endsequence
  we_width_a: assert property ($fell(flash_we_n) |-> we_low4) else $error("write strobe width");
  addr_latch_a: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n)) else $error("we fell before ce");
  data_latch_a: assert property ($rose(flash_we_n) |-> !flash_ce_n && flash_dq_oe) else $error("ce rose first");
  write_only_a: assert property (!flash_we_n |-> flash_oe_n && flash_dq_oe && $stable(flash_dq_out))
    else $error("write cycle not clean");
  read_width_a: assert property ($fell(flash_oe_n) |-> oe_low7) else $error("read strobe width");
  no_clash_a: assert property (!flash_oe_n |-> !flash_dq_oe && !flash_ce_n) else $error("bus clash");
  ce_gap_a: assert property ($rose(flash_ce_n) |=> flash_ce_n) else $error("ce high too short");
  addr_hold_a: assert property (!flash_ce_n && !$fell(flash_ce_n) |-> $stable(flash_addr))
    else $error("address moved in cycle");
  idle_strobe_a: assert property (flash_ce_n |-> flash_we_n && flash_oe_n) else $error("strobe without ce");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
endmodule // fcs_props
bind fcs_host fcs_props fcs_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pslverr(pslverr), .flash_addr(flash_addr), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
  .flash_ce_n(flash_ce_n), .flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n));
`default_nettype wire

/* File: tb/fcs_flash_model.sv */
/* behavioural eight-bank flash: command decode, array, status bits.
   assumes the bench resolves the data wire and pulls ready/busy up. */
`timescale 1ns/100ps
`default_nettype none
module fcs_flash_model
#(
  parameter int          T_PROG    = 50,
  parameter int          T_PROT    = 100,
  parameter int          T_ERASE   = 400,
  parameter int          T_EPROT   = 10000,
  parameter logic [6:0]  PROT_SECT = 7'h7f,
  parameter logic [15:0] MAKER_ID  = 16'h005a // arbitrary value
)
(
  input wire logic        ce_n,
  input wire logic        we_n,
  input wire logic        oe_n,
  input wire logic [18:0] addr,
  input wire logic [15:0] dq_in,
  output logic     [15:0] dq_out,
  output logic            dq_oe,
  output logic            rb_oe
);
  logic [15:0] mem [0:524287];
  logic [18:0] la, pa;
  logic [15:0] pd;
  logic [6:0]  es;
  logic        prog = 0, ers = 0, susp = 0, byp = 0, idm = 0, pend = 0, t1 = 0, t2 = 0, tmo = 0;
  int          st = 0, rem = 0, erem = 0;
  initial
  begin
    dq_out = 16'h0000;
    dq_oe = 1'b0;
    foreach (mem[k]) mem[k] = 16'hffff;
  end
  assign rb_oe = prog | (ers & !susp);
  // time base runs only while busy; erase time freezes in suspend
  always #10
  begin
    if (rem > 0) rem--;
    else prog = tmo;
    if (ers && !susp && --erem == 0)
    begin
      if (es != PROT_SECT) for (int k = 0; k < 4096; k++) mem[{es, k[11:0]}] = 16'hffff;
      ers = 0;
    end
  end
  task automatic wr(input logic [15:0] d);
    logic [10:0] a;
    a = la[10:0];
    if (pend)
    begin
      pend = 0; st = 0; pa = la; pd = d; prog = 1;
      tmo = |(d & ~mem[la]);
      rem = (la[18:12] == PROT_SECT) ? T_PROT : T_PROG;
      if (la[18:12] != PROT_SECT) mem[la] = d;
    end
    else if (d[7:0] == 8'hf0) {st, idm, tmo} = 0;
    else if (st == 0 && d[7:0] == 8'hb0) susp = ers;
    else if (st == 0 && d[7:0] == 8'h30) susp = 0;
    else if (byp && st == 0 && d[7:0] == 8'ha0) pend = 1;
    else if (byp && d[7:0] == 8'h90) st = 9;
    else if (st == 9) {byp, st} = {d[7:0] != 8'h00, 32'd0};
    else if (d[7:0] == 8'haa && (st == 0 || st == 3) && a == 11'h555) st++;
    else if (d[7:0] == 8'h55 && (st == 1 || st == 4) && a == 11'h2aa) st++;
    else if (st == 2 && a == 11'h555)
    begin
      st = (d[7:0] == 8'h80) ? 3 : 0;
      pend = d[7:0] == 8'ha0;
      byp = byp | (d[7:0] == 8'h20);
      idm = d[7:0] == 8'h90;
    end
    else if (st == 5 && d[7:0] == 8'h30)
    begin
      {es, ers, st} = {la[18:12], 1'b1, 32'd0};
      erem = (es == PROT_SECT) ? T_EPROT : T_ERASE;
    end
    else st = 0;
  endtask
  function automatic logic [15:0] rv(input logic [18:0] a);
    if (idm) return (a[7:0] == 8'h02) ? {15'h0, a[18:12] == PROT_SECT} : MAKER_ID;
    if (prog && a[18:16] == pa[18:16]) return {8'h00, ~pd[7], t1, tmo, 5'h00};
    if (ers && a[18:12] == es) return {8'h00, susp, t1, 3'h0, t2, 2'h0};
    if (ers && !susp && a[18:16] == es[6:4]) return {8'h00, 1'b0, t1, 6'h00};
    return mem[a];
  endfunction
  always @(negedge we_n) if (!ce_n) la = addr;
  always @(posedge we_n) if (!ce_n) wr(dq_in);
  always @(negedge oe_n) if (!ce_n) {dq_out, dq_oe} = {rv(addr), 1'b1};
  always @(posedge oe_n)
  begin
    dq_oe = 1'b0;
    t1 ^= (prog && addr[18:16] == pa[18:16]) || (ers && !susp && addr[18:16] == es[6:4]);
    t2 ^= ers && addr[18:12] == es;
  end
endmodule // fcs_flash_model
`default_nettype wire

/* File: tb/tb.sv */
/* self-checking bench for fcs_host: apb master, flash model, scenarios.
   assumes fcs_consts.vh on the include path. */
`include "fcs_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, dq_oe, ce_n, we_n, oe_n, m_oe, m_rb, rb_n;
  logic [18:0] flash_addr;
  logic [15:0] dq_out, dq_in, m_out;
  logic [3:0]  bad [7] = '{`FCS_OP_BYP_PROG, `FCS_OP_SUSPEND, `FCS_OP_RESUME, 4'hc, 4'hd, 4'he, 4'hf};
  int          n_fail = 0, n_compared = 0, cyc = 0;
  // released bus shows the inverse of the model's last output, never a held copy
  assign dq_in = dq_oe ? dq_out : (m_oe ? m_out : ~m_out);
  assign rb_n = !m_rb;
  always #5 pclk = ~pclk;
  fcs_host fcs_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .ready_busy_n(rb_n));
  fcs_flash_model fcs_flash_model_inst (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(flash_addr),
    .dq_in(dq_in), .dq_out(m_out), .dq_oe(m_oe), .rb_oe(m_rb));
  task end_of_test;
    if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task cmd(input logic [3:0] op, input logic [18:0] a, input logic [15:0] d, output logic [31:0] st);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `FCS_REG_ADDR, {13'h0, a}, r, e);
    apb(1'b1, `FCS_REG_WDATA, {16'h0, d}, r, e);
    apb(1'b1, `FCS_REG_CTRL, {28'h0, op}, r, e);
    st = 32'h1;
    for (int i = 0; i < 5000 && st[0] !== 1'b0; i++) apb(1'b0, `FCS_REG_STATUS, 32'h0, st, e);
  endtask
  task rd(input logic [18:0] a, output logic [31:0] v);
    logic [31:0] st;
    logic        e;
    cmd(`FCS_OP_READ, a, 16'h0, st);
    apb(1'b0, `FCS_REG_RDATA, 32'h0, v, e);
  endtask
  // status word after a finished command: done set, busy clear
  function logic [31:0] stw(input logic err, byp, ers, sus, rdy);
    return {24'h0, rdy, sus, ers, byp, 1'b0, err, 2'b10};
  endfunction
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  initial
  begin
    logic [31:0] st, r;
    logic        e;
    logic [18:0] a;
    logic [15:0] d;
    void'($urandom(32'hb339));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `FCS_REG_STATUS, 32'h0, r, e);
    chk(r, stw(0, 0, 0, 0, 1) & 32'h80);
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      a = {3'd1, 16'($urandom)};
      d = (i == 0) ? 16'h0080 : 16'($urandom);
      cmd(`FCS_OP_PROG, a, d, st);
      chk(st, stw(0, 0, 0, 0, 1));
      rd(a, r);
      chk(r, {16'h0, d});
    end
    cmd(`FCS_OP_PROG, {7'h7f, 12'h123}, 16'h1234, st);
    chk(st, stw(0, 0, 0, 0, 1));
    rd({7'h7f, 12'h123}, r);
    chk(r, 32'hffff);
    foreach (bad[i])
    begin
      cmd(bad[i], a, 16'h0, st);
      chk(st, stw(1, 0, 0, 0, 1));
    end
    cmd(`FCS_OP_BYP_ENTER, a, 16'h0, st);
    chk(st, stw(0, 1, 0, 0, 1));
    a = a ^ 19'h1;
    d = 16'($urandom);
    cmd(`FCS_OP_BYP_PROG, a, d, st);
    chk(st, stw(0, 1, 0, 0, 1));
    cmd(`FCS_OP_PROG, a, d, st);
    chk(st, stw(1, 1, 0, 0, 1));
    cmd(`FCS_OP_BYP_RESET, a, 16'h0, st);
    chk(st, stw(0, 0, 0, 0, 1));
    rd(a, r);
    chk(r, {16'h0, d});
    for (int i = 0; i < 2; i++)
    begin
      cmd(`FCS_OP_AUTOSEL, {i ? 7'h7f : 7'h10, 12'h002}, 16'h0, st);
      apb(1'b0, `FCS_REG_RDATA, 32'h0, r, e);
      chk(r, {31'h0, i == 1});
      cmd(`FCS_OP_RESET, {7'h10, 12'h0}, 16'h0, st);
      chk(st, stw(0, 0, 0, 0, 1));
    end
    cmd(`FCS_OP_PROG, {7'h05, 12'h0}, 16'h0000, st);
    cmd(`FCS_OP_PROG, {7'h05, 12'h0}, 16'h0001, st);
    chk(st, stw(1, 0, 0, 0, 0) | 32'h8);
    cmd(`FCS_OP_RESET, {7'h05, 12'h0}, 16'h0, st);
    chk(st, stw(0, 0, 0, 0, 1));
    cmd(`FCS_OP_SECT_ER, {7'h05, 12'h0}, 16'h0, st);
    chk(st, stw(0, 0, 1, 0, 0));
    rd(a, r);
    chk(r, {16'h0, d});
    cmd(`FCS_OP_SUSPEND, {7'h05, 12'h0}, 16'h0, st);
    chk(st, stw(0, 0, 1, 1, 1));
    cmd(`FCS_OP_RESUME, {7'h05, 12'h0}, 16'h0, st);
    chk(st, stw(0, 0, 1, 0, 0));
    cmd(`FCS_OP_POLL, {7'h05, 12'h0}, 16'h0, st);
    chk(st, stw(0, 0, 0, 0, 1));
    rd({7'h05, 12'h0}, r);
    chk(r, 32'hffff);
    cmd(`FCS_OP_SECT_ER, {7'h7f, 12'h0}, 16'h0, st);
    cmd(`FCS_OP_POLL, {7'h7f, 12'h0}, 16'h0, st);
    chk(st, stw(0, 0, 0, 0, 1));
    end_of_test;
  end
endmodule // tb
`default_nettype wire
